// ---- rtl/sprc_core.sv ----
// Serial peripheral controller: APB registers, master/slave shift engine
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defs.svh"
// Function
// - Control bits 7,1,0 select clock rate
// - Control bit 6 enables interface
// - Bit 5 ignores select, not slave phase0
// - Control bit 4 selects master role
// - Control bit 3 sets clock idle level
// - Control bit 2 selects sampling edge
// - Rate codes divide 2..128, 111 external
// - Status bit 7 transfer done flag
// - Status bit 6 write collision flag
// - Status bit 4 mode fault flag
// - Data write loads shift register directly
// - Data read returns receive buffer
// - Registers accessible when no exchange running
// - Clearing enable aborts transfer at once
// - Done clears: status read, data read
// - Master mode fault drops enable, master
// - Fault clears: status read, control write
// - Collision: no interrupt, clears status+data
module sprc_core
  import sprc_pkg::*;
(
  input  wire logic        i_mclk,     // Peripheral clock
  input  wire logic        i_reset,    // Sync reset, active high
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction
  input  wire logic [11:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  input  wire logic        i_brg_tick, // Baud generator pulse
  input  wire logic        i_sck,      // Serial clock in (slave)
  output logic             o_sck,      // Serial clock out
  output logic             o_sck_oe_n, // Clock enable, low drives
  input  wire logic        i_miso,     // Data in (master)
  output logic             o_miso,     // Data out (slave)
  output logic             o_miso_oe_n,// Slave data enable, low
  input  wire logic        i_mosi,     // Data in (slave)
  output logic             o_mosi,     // Data out (master)
  output logic             o_mosi_oe_n,// Master data enable, low
  input  wire logic        i_ss_n,     // Slave select, active low
  output logic             o_tx_irq,   // Transmitter request
  output logic             o_err_irq   // Mode fault request
);

  logic [7:0]  ctl_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  rxbuf_reg;
  logic        done_reg;
  logic        write_collision_flag_reg;
  logic        mode_fault_flag_reg;
  logic        stat_rd_reg;
  logic        busy_reg;
  logic [3:0]  bits_reg;
  logic        sck_reg;
  logic [6:0]  div_reg;
  logic        sck_in_reg;
  logic        ss_prev_reg;
  logic        smp_reg;
  sprc_state_t state_reg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // Bus decode
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire sel_ctl  = hit(paddr, `SPRC_OFF_CONTROL);
  wire sel_sta  = hit(paddr, `SPRC_OFF_STATUS);
  wire sel_dat  = hit(paddr, `SPRC_OFF_DATA);
  wire mapped   = sel_ctl | sel_sta | sel_dat;
  wire wr_ctl   = wr & sel_ctl;
  wire wr_dat   = wr & sel_dat;
  wire rd_sta   = rd & sel_sta;
  wire acc_dat  = acc & sel_dat;
  wire rd_dat   = rd & sel_dat;

  // Configuration fields
  // interface enable bit
  wire enable   = ctl_reg[`SPRC_CTL_ENABLE];
  wire master   = ctl_reg[`SPRC_CTL_MASTER];
  wire clock_idle_level     = ctl_reg[`SPRC_CTL_CLOCK_IDLE_LEVEL];
  wire sample_edge_select     = ctl_reg[`SPRC_CTL_SAMPLE_EDGE_SELECT];
  wire ss_ign   = ctl_reg[`SPRC_CTL_SS_IGN];
  wire [2:0] rate = {ctl_reg[`SPRC_CTL_RATE_HI],
                     ctl_reg[`SPRC_CTL_RATE_MID],
                     ctl_reg[`SPRC_CTL_RATE_LO]};

  wire [6:0] div_lim = 7'(({7'h0, 1'b1} << rate) - 7'h1);
  wire half_tick = (rate == `SPRC_RATE_EXT) ? i_brg_tick
                                            : (div_reg >= div_lim);

  wire ss_used  = ~ss_ign | (~master & ~sample_edge_select);
  wire ss_act   = ss_used & ~i_ss_n;
  wire slave_on = enable & ~master & (ss_act | ~ss_used);
  wire mode_fault_flag_set = enable & master & ~ss_ign & ~i_ss_n;

  // Slave clock edges, idle-relative
  wire sck_lvl  = i_sck ^ clock_idle_level;
  wire s_lead   = slave_on & sck_lvl & ~sck_in_reg;
  wire s_trail  = slave_on & ~sck_lvl & sck_in_reg;
  wire ss_fall  = ~i_ss_n & ss_prev_reg;
  wire s_sample = sample_edge_select ? s_trail : s_lead;
  wire s_shift  = sample_edge_select ? s_lead  : s_trail;
  wire s_data   = i_mosi;

  // Master edges from the divider
  wire m_run    = enable & master & busy_reg;
  wire m_lead   = m_run & half_tick & (state_reg != SPRC_TRAIL);
  wire m_trail  = m_run & half_tick & (state_reg == SPRC_TRAIL);
  wire m_sample = sample_edge_select ? m_trail : m_lead;
  wire m_shift  = sample_edge_select ? m_lead  : m_trail;

  wire sample   = master ? m_sample : s_sample;
  wire shift_ev = master ? m_shift  : s_shift;
  wire in_bit   = master ? i_miso   : s_data;
  wire last_bit = (bits_reg == `SPRC_BITS - 4'h1);
  // Phase 0 ends on the last trailing edge, so all 8 clocks go out
  wire end_p0   = ~sample_edge_select & shift_ev & (bits_reg == `SPRC_BITS);
  wire end_p1   = sample_edge_select & sample & last_bit;
  wire xfer_end = busy_reg & (end_p0 | end_p1);
  // Output changes only on the shift edge, never on the sample edge
  wire do_shift = busy_reg & shift_ev & (bits_reg != 4'h0);
  wire [7:0] shift_nxt = {shift_reg[6:0], smp_reg};
  wire [7:0] rx_nxt    = end_p1 ? {shift_reg[6:0], in_bit} : shift_nxt;
  wire load     = wr_dat & ~busy_reg;
  wire write_collision_flag_set = wr_dat & busy_reg;
  wire s_start  = ~master & slave_on & ~busy_reg &
                  (sample_edge_select ? s_lead : (ss_fall | s_sample));

  // Sticky pending-clear marker after status read
  wire stat_seen = stat_rd_reg | rd_sta;

  wire abort    = ~enable;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctl_reg <= `SPRC_CTL_RESET;
    end else if (mode_fault_flag_set) begin
      ctl_reg[`SPRC_CTL_ENABLE] <= 1'b0;
      ctl_reg[`SPRC_CTL_MASTER] <= 1'b0;
    end else if (wr_ctl) begin
      ctl_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      div_reg <= 7'h0;
    end else if (~m_run | half_tick) begin
      div_reg <= 7'h0;
    end else begin
      div_reg <= div_reg + 7'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sck_in_reg  <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sck_in_reg  <= sck_lvl;
      ss_prev_reg <= i_ss_n;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || abort) begin
      busy_reg  <= 1'b0;
      bits_reg  <= 4'h0;
      sck_reg   <= 1'b0;
      state_reg <= SPRC_IDLE;
    end else if (load && master) begin
      busy_reg  <= 1'b1;
      bits_reg  <= 4'h0;
      state_reg <= SPRC_LEAD;
    end else if (s_start) begin
      busy_reg  <= 1'b1;
      bits_reg  <= (!sample_edge_select && s_sample) ? 4'h1 : 4'h0;
    end else if (xfer_end) begin
      busy_reg  <= 1'b0;
      bits_reg  <= 4'h0;
      sck_reg   <= 1'b0;
      state_reg <= SPRC_IDLE;
    end else begin
      if (sample) begin
        bits_reg <= bits_reg + 4'h1;
      end
      if (m_lead) begin
        sck_reg   <= 1'b1;
        state_reg <= SPRC_TRAIL;
      end else if (m_trail) begin
        sck_reg   <= 1'b0;
        state_reg <= SPRC_LEAD;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      shift_reg <= 8'h00;
    end else if (load) begin
      shift_reg <= pwdata[7:0];
    end else if (do_shift) begin
      shift_reg <= shift_nxt;
    end
  end

  // Sampled bit held until the shift edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      smp_reg <= 1'b0;
    end else if (sample) begin
      smp_reg <= in_bit;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rxbuf_reg <= 8'h00;
    end else if (xfer_end) begin
      rxbuf_reg <= rx_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      stat_rd_reg <= 1'b0;
    end else if (acc_dat || wr_ctl) begin
      stat_rd_reg <= 1'b0;
    end else if (rd_sta) begin
      stat_rd_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      done_reg <= 1'b0;
    end else if (xfer_end) begin
      done_reg <= 1'b1;
    end else if ((rd_dat && stat_rd_reg) || load) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      write_collision_flag_reg <= 1'b0;
    end else if (write_collision_flag_set) begin
      write_collision_flag_reg <= 1'b1;
    end else if (acc_dat && stat_rd_reg) begin
      write_collision_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_fault_flag_reg <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_reg <= 1'b1;
    end else if (wr_ctl && stat_rd_reg) begin
      mode_fault_flag_reg <= 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  wire [7:0] sta_val = {done_reg, write_collision_flag_reg, 1'b0, mode_fault_flag_reg, 4'h0};
  wire [7:0] rd_val  = sel_ctl ? ctl_reg :
                       sel_sta ? sta_val :
                       sel_dat ? rxbuf_reg : 8'h00;
  assign prdata = {24'h0, rd_val};

  assign o_sck       = sck_reg ^ clock_idle_level;
  assign o_sck_oe_n  = ~(enable & master);
  assign o_mosi      = shift_reg[7];
  assign o_mosi_oe_n = ~(enable & master);
  assign o_miso      = shift_reg[7];
  assign o_miso_oe_n = ~(slave_on & (ss_act | ~ss_used));
  assign o_tx_irq    = done_reg;
  assign o_err_irq   = mode_fault_flag_reg & ~ss_ign;

  wire unused_ok = stat_seen;

endmodule // sprc_core
`default_nettype wire

// ---- pkg/sprc_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SPRC_DEFS_SVH
`define SPRC_DEFS_SVH
`define SPRC_OFF_CONTROL  12'h000
`define SPRC_OFF_STATUS   12'h004
`define SPRC_OFF_DATA     12'h008
`define SPRC_CTL_RATE_HI  7
`define SPRC_CTL_ENABLE   6
`define SPRC_CTL_SS_IGN   5
`define SPRC_CTL_MASTER   4
`define SPRC_CTL_CLOCK_IDLE_LEVEL     3
`define SPRC_CTL_SAMPLE_EDGE_SELECT     2
`define SPRC_CTL_RATE_MID 1
`define SPRC_CTL_RATE_LO  0
`define SPRC_STA_DONE     7
`define SPRC_STA_WRITE_COLLISION_FLAG     6
`define SPRC_STA_MODE_FAULT_FLAG     4
`define SPRC_CTL_RESET    8'h14
`define SPRC_BITS         4'h8
`define SPRC_RATE_EXT     3'h7
`endif

// ---- pkg/sprc_pkg.sv ----
// Types shared by the serial peripheral controller
package sprc_pkg;
  typedef enum logic [1:0] {
    SPRC_IDLE,
    SPRC_LEAD,
    SPRC_TRAIL
  } sprc_state_t;
endpackage

// ---- bench/sprc_asserts.sv ----
// Port checks for the serial controller
`timescale 1ns/1ps
`default_nettype none
module sprc_asserts (
  input wire logic        i_mclk,      // Clock
  input wire logic        i_reset,     // Reset
  input wire logic        psel,        // Select
  input wire logic        penable,     // Access
  input wire logic        pwrite,      // Write
  input wire logic [11:0] paddr,       // Address
  input wire logic [31:0] pwdata,      // Wdata
  input wire logic [31:0] prdata,      // Rdata
  input wire logic        pready,      // Ready
  input wire logic        pslverr,     // Error
  input wire logic        o_sck_oe_n,  // Clock oe
  input wire logic        o_mosi_oe_n, // Data oe
  input wire logic        o_tx_irq,    // Done irq
  input wire logic        o_err_irq    // Fault irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire acc = psel && penable;
  wire rda = acc && !pwrite;
  wire wra = acc && pwrite;
  wire hit = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
  pready_now_a: assert property (acc |-> pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && !hit |-> pslverr)
    else $error("no pslverr");
  upper_zero_a: assert property (rda |-> prdata[31:8] == 24'h0)
    else $error("prdata high bits");
  done_irq_a: assert property (rda && paddr == 12'h004 |->
    prdata[7] == o_tx_irq) else $error("tx irq differs");
  ctl_drive_a: assert property (wra && paddr == 12'h000 &&
    pwdata[5] |=> o_sck_oe_n == !$past(pwdata[6] && pwdata[4]))
    else $error("clock enable wrong");
  fault_drop_a: assert property (
    $rose(o_err_irq) |-> ##[0:1] o_sck_oe_n) else $error("fault kept master");
  mosi_oe_a: assert property (o_sck_oe_n |-> o_mosi_oe_n)
    else $error("data without clock");
  load_clear_a: assert property (wra && paddr == 12'h008 |=> !o_tx_irq)
    else $error("done after load");
  done_c: cover property ($rose(o_tx_irq));
  fault_c: cover property ($rose(o_err_irq));
  unmapped_c: cover property (acc && !hit);
endmodule // sprc_asserts
bind sprc_core sprc_asserts u_chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .o_sck_oe_n(o_sck_oe_n), .o_mosi_oe_n(o_mosi_oe_n),
  .o_tx_irq(o_tx_irq), .o_err_irq(o_err_irq));
`default_nettype wire

// ---- bench/sprc_slave_model.sv ----
// Serial slave that answers the controller
`timescale 1ns/1ps
`default_nettype none
module sprc_slave_model (
  input  wire logic       i_sck,   // Serial clock
  input  wire logic       i_sel_n, // Select
  input  wire logic       i_mosi,  // Data in
  input  wire logic [7:0] i_tx,    // Reply byte
  output logic            o_miso,  // Data out
  output logic      [7:0] o_rx     // Captured byte
);
  logic [7:0] tx_reg;
  logic       last_reg = 1'b0;
  assign o_miso = i_sel_n ? ~last_reg : tx_reg[7];
  always @(negedge i_sel_n) tx_reg <= i_tx;
  always @(posedge i_sck) if (!i_sel_n) o_rx <= {o_rx[6:0], i_mosi};
  always @(negedge i_sck) if (!i_sel_n) begin
    last_reg <= tx_reg[7];
    tx_reg   <= {tx_reg[6:0], 1'b0};
  end
endmodule // sprc_slave_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Bench: registers and transfers of the serial controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_mclk = 1'b0, i_reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, tick = 1'b0, ss_n = 1'b1, sel_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  s_tx = 8'h00, s_rx;
  logic        pready, pslverr, err, sck, oe_n, miso, mosi, mo_n, txi, eri;
  int          miscompares = 0, check_count = 0, cyc = 0, t0, e;
  wire         sck_w = oe_n ? 1'b0 : sck;
  wire         mosi_w = mo_n ? 1'b1 : mosi;
  sprc_core uut (.i_mclk(i_mclk), .i_reset(i_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_brg_tick(tick),
    .i_sck(sck_w), .o_sck(sck), .o_sck_oe_n(oe_n), .i_miso(miso),
    .o_miso(), .o_miso_oe_n(), .i_mosi(mosi_w), .o_mosi(mosi),
    .o_mosi_oe_n(mo_n), .i_ss_n(ss_n), .o_tx_irq(txi), .o_err_irq(eri));
  sprc_slave_model u_slv (.i_sck(sck_w), .i_sel_n(sel_n), .i_mosi(mosi_w),
    .i_tx(s_tx), .o_miso(miso), .o_rx(s_rx));
  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc  <= cyc + 1;
    tick <= cyc[1:0] == 2'b00;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic stop();
    miscompares++;
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) stop();
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, logic [11:0] a, logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, x);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (txi !== 1'b1 && n < 3000);
    if (txi !== 1'b1) stop();
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    rchk("ctl", 12'h000, 32'hff, 32'h14);
    rchk("sta", 12'h004, 32'hd0, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    rchk("sta0", 12'h004, 32'hd0, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", err, 1'b1);
    for (int r = 0; r < 8; r++) begin
      e = r == 7 ? 64 : 16 << r;
      apb(1'b1, 12'h000, {24'h0, r[2], 5'b11100, r[1:0]});
      s_tx  <= 8'ha5 ^ 8'(r);
      sel_n <= 1'b0;
      apb(1'b1, 12'h008, 32'h3c + r);
      t0 = cyc;
      if (r == 6) apb(1'b1, 12'h008, 32'hff);
      wait_tx();
      chk("length", 32'((cyc - t0) > e - 5 && (cyc - t0) < e + 5), 1);
      chk("mosi", s_rx, 32'h3c + r);
      chk("txirq", txi, 1'b1);
      rchk("done", 12'h004, 32'hd0, r == 6 ? 32'hc0 : 32'h80);
      rchk("rx", 12'h008, 32'hff, 32'ha5 ^ r);
      rchk("clr", 12'h004, 32'hd0, 32'h0);
      sel_n <= 1'b1;
    end
    apb(1'b1, 12'h000, 32'hf2);
    apb(1'b1, 12'h008, 32'h5a);
    repeat (40) @(posedge i_mclk);
    apb(1'b1, 12'h000, 32'hb2);
    @(negedge i_mclk);
    chk("abort", {oe_n, mo_n}, 2'b11);
    repeat (2100) @(posedge i_mclk);
    chk("nodone", txi, 1'b0);
    apb(1'b1, 12'h000, 32'h78);
    @(negedge i_mclk);
    chk("idle", sck, 1'b1);
    ss_n <= 1'b0;
    apb(1'b1, 12'h000, 32'h50);
    repeat (2) @(negedge i_mclk);
    chk("errirq", eri, 1'b1);
    rchk("mode_fault_flag", 12'h004, 32'h10, 32'h10);
    rchk("ctlf", 12'h000, 32'hff, 32'h0);
    apb(1'b1, 12'h000, 32'h14);
    rchk("modfclr", 12'h004, 32'h10, 32'h0);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
